// ### src/dtl_tuning_loader.sv
// DDS tuning word loader: serial write port, tuning registers, accumulator and output selector
//
// Overview of operation
// - Two 28-bit tuning registers; the tuning select bit picks which feeds the accumulator.
// - Two 12-bit phase offsets; the offset select bit picks which gets added.
// - Accumulator adds the selected tuning word each clock, wrapping at two to 28.
// - One unit of phase offset shifts output by one 4096th of a cycle.
// - Serial address 01 loads tuning word a, 10 tuning word b, 14 data bits.
// - Serial address 00 writes the control word.
// - Full-width load: first write gives low 14 bits, second the upper 14.
// - Half load: half select 1 writes upper half, 0 lower; other half kept.
// - Address 11 loads phase; bit 13 selects register, bits 11..0 carry value.
// - Reset bit clears accumulator, output at midscale; word registers keep contents.
// - Output appears seven clocks after the reset bit returns to zero.
// - Two sleep bits: none, converter down, clock gated, or both.
// - Clock gated: accumulator and output hold; serial writes still accepted.
// - Ungating resumes accumulation; changes reach the output after pipeline latency.
// - Selector: sine, ramp, halved data MSB, or plain data MSB; one code reserved.
// - Ramp mode bypasses sine lookup, sending truncated phase up then down.
// - Square mode optionally divides the data MSB by two per the divide bit.
// - Frame sync low frames 16 bits MSB first, sampled on serial clock fall.
// - Control word bit positions for selects, reset, sleep, output and mode.
`timescale 1ns/10ps
module dtl_tuning_loader #(
    parameter int ACC_W = dtl_pkg::ACC_W,
    parameter int PH_W = dtl_pkg::PH_W,
    parameter int DAC_W = dtl_pkg::DAC_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic frame_sync_n,
    input wire logic serial_in,
    output logic [DAC_W-1:0] wave_out,
    output logic bitOut,
    output logic converterEnable,
    output logic waveValid
);
    //--------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------
    // The serial clock is slow against clk, so it is sampled as data
    logic [1:0] sclkSync_r;
    logic [1:0] fsyncSync_r;
    logic [1:0] sdataSync_r;
    logic sclkPrev_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclkSync_r <= 2'h3;
            fsyncSync_r <= 2'h3;
            sdataSync_r <= 2'h0;
            sclkPrev_r <= 1'b1;
        end else begin
            sclkSync_r <= {sclkSync_r[0], serialClk};
            fsyncSync_r <= {fsyncSync_r[0], frame_sync_n};
            sdataSync_r <= {sdataSync_r[0], serial_in};
            sclkPrev_r <= sclkSync_r[1];
        end
    end
    logic sclkFall;
    logic frameActive;
    assign sclkFall = sclkPrev_r & ~sclkSync_r[1];
    assign frameActive = ~fsyncSync_r[1];

    //--------------------------------------------------------------
    // Serial word receiver
    //--------------------------------------------------------------
    dtl_pkg::dtl_ser_state_t serState_r;
    logic [15:0] shift_r;
    logic [4:0] bitCnt_r;
    logic wordStrobe_r;
    logic [15:0] word_r;
    // 16 bits MSB first, taken on serial clock fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serState_r <= dtl_pkg::SER_IDLE;
            shift_r <= 16'h0000;
            bitCnt_r <= 5'h00;
            wordStrobe_r <= 1'b0;
            word_r <= 16'h0000;
        end else begin
            wordStrobe_r <= 1'b0;
            unique case (serState_r)
                dtl_pkg::SER_IDLE: begin
                    bitCnt_r <= 5'h00;
                    if (frameActive) begin
                        serState_r <= dtl_pkg::SER_SHIFT;
                    end
                end
                dtl_pkg::SER_SHIFT: begin
                    if (!frameActive) begin
                        // A frame cut short is dropped
                        serState_r <= dtl_pkg::SER_IDLE;
                    end else if (sclkFall) begin
                        shift_r <= {shift_r[14:0], sdataSync_r[1]};
                        bitCnt_r <= bitCnt_r + 5'h01;
                        if (bitCnt_r == 5'(dtl_pkg::SER_BITS - 1)) begin
                            word_r <= {shift_r[14:0], sdataSync_r[1]};
                            wordStrobe_r <= 1'b1;
                            serState_r <= dtl_pkg::SER_DONE;
                        end
                    end
                end
                dtl_pkg::SER_DONE: begin
                    // Extra clocks in the same frame are ignored until sync rises
                    if (!frameActive) begin
                        serState_r <= dtl_pkg::SER_IDLE;
                    end
                end
                default: begin
                    serState_r <= dtl_pkg::SER_IDLE;
                end
            endcase
        end
    end

    //--------------------------------------------------------------
    // Control word
    //--------------------------------------------------------------
    dtl_pkg::dtl_ctrl_t ctrl_r;
    logic [1:0] addr;
    assign addr = word_r[15:14];
    // Control word write with its bit map
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= '{fullWidthLoad: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_FULL],
                        halfSelect: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_HALF],
                        tuningSelect: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_TSEL],
                        offsetSelect: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_OSEL],
                        resetBit: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_RESET],
                        clockGateSleep: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_GATE],
                        converterPowerdown: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_PDN],
                        bitOutputEnable: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_OPEN],
                        squareDivideBypass: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_DIV],
                        waveMode: dtl_pkg::CTRL_RST_VAL[dtl_pkg::BIT_MODE]};
        end else if (wordStrobe_r && addr == dtl_pkg::ADDR_CTRL) begin
            ctrl_r.fullWidthLoad <= word_r[dtl_pkg::BIT_FULL];
            ctrl_r.halfSelect <= word_r[dtl_pkg::BIT_HALF];
            ctrl_r.tuningSelect <= word_r[dtl_pkg::BIT_TSEL];
            ctrl_r.offsetSelect <= word_r[dtl_pkg::BIT_OSEL];
            ctrl_r.resetBit <= word_r[dtl_pkg::BIT_RESET];
            ctrl_r.clockGateSleep <= word_r[dtl_pkg::BIT_GATE];
            ctrl_r.converterPowerdown <= word_r[dtl_pkg::BIT_PDN];
            ctrl_r.bitOutputEnable <= word_r[dtl_pkg::BIT_OPEN];
            ctrl_r.squareDivideBypass <= word_r[dtl_pkg::BIT_DIV];
            ctrl_r.waveMode <= word_r[dtl_pkg::BIT_MODE];
        end
    end

    //--------------------------------------------------------------
    // Tuning and phase registers
    //--------------------------------------------------------------
    logic [ACC_W-1:0] tuning_word_a_r;
    logic [ACC_W-1:0] tuning_word_b_r;
    logic [dtl_pkg::HALF_W-1:0] lowPending_r;
    logic pendingValid_r;
    logic pendingTarget_r;
    logic [PH_W-1:0] phase_offset_a_r;
    logic [PH_W-1:0] phase_offset_b_r;
    logic tuneWrite;
    logic tuneTarget;
    logic [dtl_pkg::HALF_W-1:0] tuneData;
    logic [ACC_W-1:0] tuneOld;
    logic [ACC_W-1:0] tuneNew;
    assign tuneWrite = wordStrobe_r && (addr == dtl_pkg::ADDR_TUNE_A || addr == dtl_pkg::ADDR_TUNE_B);
    assign tuneTarget = (addr == dtl_pkg::ADDR_TUNE_B);
    assign tuneData = word_r[dtl_pkg::HALF_W-1:0];
    assign tuneOld = tuneTarget ? tuning_word_b_r : tuning_word_a_r;
    always_comb begin
        tuneNew = tuneOld;
        if (ctrl_r.fullWidthLoad) begin
            tuneNew = {tuneData, lowPending_r};
        end else if (ctrl_r.halfSelect) begin
            tuneNew = {tuneData, tuneOld[dtl_pkg::HALF_W-1:0]};
        end else begin
            tuneNew = {tuneOld[ACC_W-1:dtl_pkg::HALF_W], tuneData};
        end
    end
    logic commitTune;
    // second write to the same address completes the word
    assign commitTune = tuneWrite && (!ctrl_r.fullWidthLoad || (pendingValid_r && pendingTarget_r == tuneTarget));
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pendingValid_r <= 1'b0;
            pendingTarget_r <= 1'b0;
            lowPending_r <= '0;
        end else if (tuneWrite && ctrl_r.fullWidthLoad) begin
            if (commitTune) begin
                pendingValid_r <= 1'b0;
            end else begin
                // first half is the low bits
                pendingValid_r <= 1'b1;
                pendingTarget_r <= tuneTarget;
                lowPending_r <= tuneData;
            end
        end else if (wordStrobe_r && addr == dtl_pkg::ADDR_CTRL) begin
            pendingValid_r <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tuning_word_a_r <= dtl_pkg::TUNE_RST_VAL;
            tuning_word_b_r <= dtl_pkg::TUNE_RST_VAL;
        end else if (commitTune) begin
            if (tuneTarget) begin
                tuning_word_b_r <= tuneNew;
            end else begin
                tuning_word_a_r <= tuneNew;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_offset_a_r <= dtl_pkg::PH_RST_VAL;
            phase_offset_b_r <= dtl_pkg::PH_RST_VAL;
        end else if (wordStrobe_r && addr == dtl_pkg::ADDR_PHASE) begin
            if (word_r[dtl_pkg::BIT_PSEL]) begin
                phase_offset_b_r <= word_r[PH_W-1:0];
            end else begin
                phase_offset_a_r <= word_r[PH_W-1:0];
            end
        end
    end

    //--------------------------------------------------------------
    // Phase accumulator
    //--------------------------------------------------------------
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] tuningValue;
    logic [PH_W-1:0] offsetValue;
    logic run;
    assign tuningValue = ctrl_r.tuningSelect ? tuning_word_b_r : tuning_word_a_r;
    assign offsetValue = ctrl_r.offsetSelect ? phase_offset_b_r : phase_offset_a_r;
    assign run = ~ctrl_r.clockGateSleep;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_r <= '0;
        end else if (ctrl_r.resetBit) begin
            acc_r <= '0;
        end else if (run) begin
            acc_r <= acc_r + tuningValue;
        end
    end

    //--------------------------------------------------------------
    // Phase to amplitude
    //--------------------------------------------------------------
    logic [PH_W-1:0] phase_r;
    logic [DAC_W-1:0] sine_r;
    logic [DAC_W-1:0] ramp;
    logic [DAC_W-1:0] sineLut [0:(1<<(PH_W-2))-1];
    // Quarter-wave table, quadrant folding keeps it to 1024 entries
    for (genvar i = 0; i < (1 << (PH_W - 2)); i++) begin : gLut
        localparam real ANG = 3.14159265358979 / 2.0 * (real'(i) + 0.5) / real'(1 << (PH_W - 2));
        assign sineLut[i] = DAC_W'(int'($floor(511.0 * $sin(ANG) + 0.5)));
    end
    logic [PH_W-3:0] lutIdx;
    logic [DAC_W-1:0] lutVal;
    assign lutIdx = phase_r[PH_W-2] ? ~phase_r[PH_W-3:0] : phase_r[PH_W-3:0];
    assign lutVal = sineLut[lutIdx];
    // triangle from truncated phase, no lookup
    assign ramp = phase_r[PH_W-1] ? ~phase_r[PH_W-2:PH_W-DAC_W-1] : phase_r[PH_W-2:PH_W-DAC_W-1];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phase_r <= '0;
            sine_r <= dtl_pkg::MIDSCALE;
        end else if (ctrl_r.resetBit) begin
            phase_r <= '0;
            sine_r <= dtl_pkg::MIDSCALE;
        end else if (run) begin
            // top 12 bits plus offset, mod 4096
            // one unit is a 4096th of a cycle
            phase_r <= acc_r[ACC_W-1:ACC_W-PH_W] + offsetValue;
            sine_r <= phase_r[PH_W-1] ? dtl_pkg::MIDSCALE - lutVal : dtl_pkg::MIDSCALE + lutVal;
        end
    end

    //--------------------------------------------------------------
    // Start latency after reset bit release
    //--------------------------------------------------------------
    logic [2:0] latCnt_r;
    // latency count holds while gated; only the reset bit restarts it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latCnt_r <= 3'h0;
        end else if (ctrl_r.resetBit) begin
            latCnt_r <= 3'h0;
        end else if (run && latCnt_r != 3'(dtl_pkg::START_LATENCY - 1)) begin
            latCnt_r <= latCnt_r + 3'h1;
        end
    end

    //--------------------------------------------------------------
    // Output selector
    //--------------------------------------------------------------
    logic msbPrev_r;
    logic msbDiv_r;
    logic dataMsb;
    logic live;
    assign dataMsb = phase_r[PH_W-1];
    assign live = (latCnt_r == 3'(dtl_pkg::START_LATENCY - 1)) && !ctrl_r.resetBit;
    // divide by two on each rising MSB
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            msbPrev_r <= 1'b0;
            msbDiv_r <= 1'b0;
        end else if (ctrl_r.resetBit) begin
            msbPrev_r <= 1'b0;
            msbDiv_r <= 1'b0;
        end else if (run) begin
            msbPrev_r <= dataMsb;
            if (dataMsb && !msbPrev_r) begin
                msbDiv_r <= ~msbDiv_r;
            end
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wave_out <= dtl_pkg::MIDSCALE;
            bitOut <= 1'b0;
            converterEnable <= 1'b1;
            waveValid <= 1'b0;
        end else begin
            converterEnable <= ~ctrl_r.converterPowerdown;
            waveValid <= live;
            if (!live) begin
                wave_out <= dtl_pkg::MIDSCALE;
                bitOut <= 1'b0;
            end else if (run) begin
                if (!ctrl_r.bitOutputEnable) begin
                    wave_out <= ctrl_r.waveMode ? ramp : sine_r;
                    bitOut <= 1'b0;
                end else if (!ctrl_r.waveMode) begin
                    wave_out <= dtl_pkg::MIDSCALE;
                    bitOut <= ctrl_r.squareDivideBypass ? dataMsb : msbDiv_r;
                end else begin
                    // Reserved code parks the output at midscale
                    wave_out <= dtl_pkg::MIDSCALE;
                    bitOut <= 1'b0;
                end
            end
        end
    end
endmodule // dtl_tuning_loader

// ### src/dtl_pkg.sv
// Package of constants and types for the DDS tuning word loader
package dtl_pkg;
    localparam int ACC_W = 28;
    localparam int HALF_W = 14;
    localparam int PH_W = 12;
    localparam int DAC_W = 10;
    localparam int SER_BITS = 16;
    localparam logic [1:0] ADDR_CTRL = 2'h0;
    localparam logic [1:0] ADDR_TUNE_A = 2'h1;
    localparam logic [1:0] ADDR_TUNE_B = 2'h2;
    localparam logic [1:0] ADDR_PHASE = 2'h3;
    localparam int BIT_FULL = 13;
    localparam int BIT_HALF = 12;
    localparam int BIT_TSEL = 11;
    localparam int BIT_OSEL = 10;
    localparam int BIT_RESET = 8;
    localparam int BIT_GATE = 7;
    localparam int BIT_PDN = 6;
    localparam int BIT_OPEN = 5;
    localparam int BIT_DIV = 3;
    localparam int BIT_MODE = 1;
    localparam int BIT_PSEL = 13;
    localparam logic [15:0] CTRL_RST_VAL = 16'h0100;
    localparam logic [ACC_W-1:0] TUNE_RST_VAL = 28'h0000000;
    localparam logic [PH_W-1:0] PH_RST_VAL = 12'h000;
    localparam logic [DAC_W-1:0] MIDSCALE = 10'h200;
    localparam int START_LATENCY = 7;
    localparam logic [2:0] LAT_CNT_MAX = 3'h7;
    typedef struct packed {
        logic fullWidthLoad;
        logic halfSelect;
        logic tuningSelect;
        logic offsetSelect;
        logic resetBit;
        logic clockGateSleep;
        logic converterPowerdown;
        logic bitOutputEnable;
        logic squareDivideBypass;
        logic waveMode;
    } dtl_ctrl_t;
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_SHIFT = 2'b01,
        SER_DONE = 2'b11
    } dtl_ser_state_t;
endpackage

// ### testbench/dtl_tuning_loader_assertions.sv
// Port-level checks for the tuning loader
`timescale 1ns/10ps
module dtl_tuning_loader_checker #(
    parameter int ACC_W = dtl_pkg::ACC_W,
    parameter int PH_W = dtl_pkg::PH_W,
    parameter int DAC_W = dtl_pkg::DAC_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serialClk,
    input wire logic frame_sync_n,
    input wire logic serial_in,
    input wire logic [DAC_W-1:0] wave_out,
    input wire logic bitOut,
    input wire logic converterEnable,
    input wire logic waveValid
);
    logic [4:0] since_r;
    // converterEnable and waveValid may only move shortly after a frame, so count clocks since one
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            since_r <= 5'h1f;
        end else if (!frame_sync_n) begin
            since_r <= 5'h00;
        end else if (since_r != 5'h1f) begin
            since_r <= since_r + 5'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_recent;
        since_r < 5'h18;
    endsequence
    sequence s_startWin;
        since_r >= 5'h05 && since_r < 5'h18;
    endsequence
    property p_idleMid;
        !waveValid |-> wave_out == dtl_pkg::MIDSCALE;
    endproperty
    a_idleMid: assert property (p_idleMid) else $error("wave_out off midscale while idle");
    property p_idleBit;
        !waveValid |-> !bitOut;
    endproperty
    a_idleBit: assert property (p_idleBit) else $error("bitOut high while idle");
    property p_release;
        $fell(rst) |-> converterEnable && !waveValid;
    endproperty
    a_release: assert property (p_release) else $error("wrong state after reset");
    property p_enableByWrite;
        $changed(converterEnable) |-> s_recent;
    endproperty
    a_enableByWrite: assert property (p_enableByWrite) else $error("enable moved without write");
    property p_start;
        $rose(waveValid) |-> s_startWin;
    endproperty
    a_start: assert property (p_start) else $error("start latency out of window");
    property p_stop;
        $fell(waveValid) |-> s_recent;
    endproperty
    a_stop: assert property (p_stop) else $error("waveValid fell without write");
    property p_quiet;
        since_r == 5'h1f |=> $stable(waveValid) && $stable(converterEnable);
    endproperty
    a_quiet: assert property (p_quiet) else $error("state moved with no write");
    property p_bitLive;
        $changed(bitOut) |-> waveValid || $past(waveValid);
    endproperty
    a_bitLive: assert property (p_bitLive) else $error("bitOut moved while idle");
endmodule // dtl_tuning_loader_checker
bind dtl_tuning_loader dtl_tuning_loader_checker #(.ACC_W(ACC_W), .PH_W(PH_W), .DAC_W(DAC_W)) chk_i (
    .clk(clk), .rst(rst), .serialClk(serialClk), .frame_sync_n(frame_sync_n), .serial_in(serial_in),
    .wave_out(wave_out), .bitOut(bitOut), .converterEnable(converterEnable), .waveValid(waveValid));

// ### testbench/dtl_host_model.sv
// Host model driving framed serial words
`timescale 1ns/10ps
module dtl_host_model (
    input wire logic clk,
    output logic serialClk,
    output logic frame_sync_n,
    output logic serial_in
);
    initial begin
        serialClk = 1'b1;
        frame_sync_n = 1'b1;
        serial_in = 1'b0;
    end
    // framed sixteen bits
    // Slow link clock: each level lasts 4 clocks so the 2-FF sync sees it
    task automatic send(input logic [15:0] word, input int gap);
        @(posedge clk);
        frame_sync_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            serial_in <= word[i];
            repeat (4) @(posedge clk);
            serialClk <= 1'b0;
            repeat (4) @(posedge clk);
            serialClk <= 1'b1;
        end
        frame_sync_n <= 1'b1;
        // Released line shows the inverse, not a stale bit
        serial_in <= ~word[0];
        repeat (8 + gap) @(posedge clk);
    endtask
endmodule // dtl_host_model

// ### testbench/dtl_tuning_loader_bench.sv
// Self-checking bench for the tuning loader
`timescale 1ns/10ps
module dtl_tuning_loader_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic serialClk, frame_sync_n, serial_in, bitOut, converterEnable, waveValid;
    logic [dtl_pkg::DAC_W-1:0] wave_out;
    logic [31:0] seed = 32'h6a49;
    int mismatches = 0;
    int totalChecks = 0;
    int ctrlM = 'h100;
    int tuneM[3] = '{0, 0, 0};
    int phM[2] = '{0, 0};
    int pendA = 0;
    int pendLow = 0;
    int r, lo, hi;
    logic [dtl_pkg::DAC_W:0] held;
    always #5 clk = ~clk;
    dtl_host_model host (.clk(clk), .serialClk(serialClk), .frame_sync_n(frame_sync_n), .serial_in(serial_in));
    dtl_tuning_loader DUT (.clk(clk), .rst(rst), .serialClk(serialClk), .frame_sync_n(frame_sync_n),
        .serial_in(serial_in), .wave_out(wave_out), .bitOut(bitOut), .converterEnable(converterEnable),
        .waveValid(waveValid));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Reference model of the word registers, updated per frame
    task automatic write(input int w);
        int a, v;
        a = (w >> 14) & 3;
        v = w & 'h3fff;
        host.send(16'(w), int'(rnd() & 32'h7));
        if (a == 0) begin
            ctrlM = w;
            pendA = 0;
        end else if (a == 3) begin
            phM[(w >> 13) & 1] = w & 'hfff;
        end else if ((ctrlM & 'h2000) != 0 && pendA == a) begin
            tuneM[a] = (v << 14) | pendLow;
            pendA = 0;
        end else if ((ctrlM & 'h2000) != 0) begin
            pendA = a;
            pendLow = v;
        end else if ((ctrlM & 'h1000) != 0) begin
            tuneM[a] = (tuneM[a] & 'h3fff) | (v << 14);
        end else begin
            tuneM[a] = (tuneM[a] & 'hfffc000) | v;
        end
    endtask
    task automatic measure(input int n);
        logic prev;
        prev = bitOut;
        r = 0;
        lo = 1023;
        hi = 0;
        repeat (n) begin
            @(negedge clk);
            if (bitOut === 1'b1 && prev === 1'b0) r++;
            prev = bitOut;
            if (int'(wave_out) < lo) lo = int'(wave_out);
            if (int'(wave_out) > hi) hi = int'(wave_out);
        end
    endtask
    task automatic checkFreq();
        int e;
        e = int'((longint'(640) * tuneM[(ctrlM & 'h800) != 0 ? 2 : 1]) >> ((ctrlM & 'h8) != 0 ? 28 : 29));
        measure(640);
        check("bitOut rises", 32'(r >= e - 1 && r <= e + 1), 32'h1);
    endtask
    task automatic waitValid(input logic lvl);
        int n;
        n = 0;
        // Look off the launching edge so a fresh update is settled
        @(negedge clk);
        while (waveValid !== lvl && n < 200) begin
            @(negedge clk);
            n++;
        end
        check("waveValid", 32'(waveValid), 32'(lvl));
        if (n == 200) tally_and_finish();
    endtask
    task automatic startPhase();
        waitValid(1'b1);
        repeat (8) @(negedge clk);
        check("bitOut start", 32'(bitOut), 32'((phM[(ctrlM >> 10) & 1] >> 11) & 1));
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check("wave_out", 32'(wave_out), 32'(dtl_pkg::MIDSCALE));
        check("converterEnable", 32'(converterEnable), 32'h1);
        // Full-width load of word a, half loads of word b
        write('h2128);
        write('h4000);
        write('h4100);
        write('h1128);
        write('h8200);
        write('h0128);
        write('h8000 | int'(rnd() & 32'h3fff));
        write('hc000 | int'(rnd() & 32'h1000));
        write('he800 | int'(rnd() & 32'h1000));
        write('h0028);
        startPhase();
        checkFreq();
        write('h0828);
        checkFreq();
        write('h0820);
        checkFreq();
        write('h0528);
        waitValid(1'b0);
        write('h0428);
        startPhase();
        checkFreq();
        // converter kept powered for sine and ramp
        write('h0000);
        measure(640);
        check("sine span", 32'(hi > 'h3c0 && lo < 'h40 && r == 0), 32'h1);
        write('h0002);
        measure(640);
        check("ramp span", 32'(hi > 'h3c0 && lo < 'h40), 32'h1);
        write('h0022);
        repeat (8) @(negedge clk);
        check("reserved", {21'h0, bitOut, wave_out}, 32'(dtl_pkg::MIDSCALE));
        for (int k = 0; k < 4; k++) begin
            write((k[0] ? 'h68 : 'h02) | (k[1] ? 'h80 : 'h00));
            repeat (8) @(negedge clk);
            check("converterEnable", 32'(converterEnable), 32'(!k[0]));
            held = {bitOut, wave_out};
            repeat (40) @(negedge clk);
            if (k[1]) check("frozen output", 32'({bitOut, wave_out}), 32'(held));
        end
        write('h10e8);
        write('h4080);
        write('h0028);
        repeat (16) @(negedge clk);
        checkFreq();
        tally_and_finish();
    end
endmodule // dtl_tuning_loader_bench
